// >>> dwl_engine.sv
// span copy to bus master and patterned line engine
`timescale 1ns/1ps
module dwl_engine
	import dwl_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// trigger write into frame buffer space
	input wire logic trig_valid,
	input wire logic [31:0] trig_addr,
	input wire logic [31:0] trig_data,
	output logic trig_ready,
	// configuration
	input wire logic [1:0] op_mode,
	input wire logic [2:0] src_bitmap,
	input wire logic [1:0] src_byte,
	input wire logic [1:0] dst_bitmap,
	input wire logic [31:0] engine_data_reg,
	input wire logic [31:0] dma_base_addr_reg,
	input wire logic [3:0] pixel_shift_reg,
	input wire logic [3:0] raster_op_config_reg,
	input wire logic [31:0] plane_mask_reg,
	input wire logic [31:0] foreground_colour_reg,
	input wire logic [31:0] background_colour_reg,
	input wire logic [31:0] bresenham_term_reg_a,
	input wire logic [31:0] bresenham_term_reg_b,
	input wire logic [31:0] bresenham_init_len_reg,
	// status
	output logic busy,
	// frame buffer quadword read
	output logic fb_rd_req,
	output logic [31:0] fb_rd_addr,
	output logic [4:0] fb_rd_format,
	input wire logic fb_rd_valid,
	input wire logic [63:0] fb_rd_data,
	// frame buffer pixel write
	output logic fb_wr_valid,
	output logic [29:0] fb_wr_dword,
	output logic [1:0] fb_wr_byte,
	output logic [31:0] fb_wr_data,
	output logic [31:0] fb_wr_plane_mask,
	output logic [3:0] fb_wr_rop,
	input wire logic fb_wr_ready,
	// bus master dword beats
	output logic pci_valid,
	output logic pci_start,
	output logic [31:0] pci_addr,
	output logic [31:0] pci_data,
	output logic [3:0] pci_be,
	output logic pci_last,
	input wire logic pci_ack,
	input wire logic pci_stop
);
	typedef struct packed
	{
		dwl_state_t st;
		logic busy;
		logic trig_ready;
		logic rd_req;
		logic [31:0] rd_addr;
		logic [4:0] rd_fmt;
		logic [16:0] total, cnt;
		logic [63:0] residue, qout;
		logic lo_en, hi_en;
		logic [3:0] lo_be, hi_be;
		logic [7:0] lmask, rmask;
		logic beat_valid;
		logic beat_start;
		logic [31:0] dw_addr;
		logic [31:0] beat_data;
		logic [3:0] beat_be;
		logic beat_last;
		logic need_start;
		logic done_seen;
		logic [31:0] cur;
		logic [15:0] err;
		logic [3:0] len;
		logic [15:0] pat;
		logic packed8;
		logic wr_valid;
		logic [31:0] wr_data;
		logic [31:0] pmask;
		logic [3:0] rop;
	} dwl_eng_state_t;
	dwl_eng_state_t s, next_s;

	dwl_stream_if #(.W(BEAT_W)) push_if ();
	dwl_stream_if #(.W(BEAT_W)) pop_if ();

	// eight deep so the reader keeps running while the bus stalls
	dwl_fifo #(.W(BEAT_W), .DEPTH(FIFO_DEPTH)) u_fifo
	(
		.mclk(mclk),
		.rst(rst),
		.wr(push_if.sink),
		.rd(pop_if.source)
	);

	// sign extend a 16-bit bresenham term to address width
	function automatic logic [31:0] sext16(input logic [15:0] v);
		sext16 = {{16{v[15]}}, v};
	endfunction

	// one beat word: last, byte enables, masked data
	function automatic logic [BEAT_W-1:0] mk_beat(input logic last, input logic [3:0] be,
		input logic [31:0] d, input logic [31:0] andm);
		mk_beat = {last, be, d & andm};
	endfunction

	logic [127:0] joined;
	logic [63:0] shifted;
	logic [6:0] shamt;

	// rotate residue and new quadword by the pixel shift in bytes
	assign joined = {fb_rd_data, s.residue};
	assign shamt = {pixel_shift_reg[3:0], 3'b000};
	assign shifted = 64'(joined >> shamt);

	// fifo fill side is driven from the emit states
	always_comb
	begin
		push_if.valid = 1'b0;
		push_if.data = '0;
		if (s.st == ST_LO && s.lo_en)
		begin
			push_if.valid = 1'b1;
			push_if.data = mk_beat(!s.hi_en && s.cnt == 17'h0_0000, s.lo_be, s.qout[31:0],
				engine_data_reg);
		end
		else if (s.st == ST_HI && s.hi_en)
		begin
			push_if.valid = 1'b1;
			push_if.data = mk_beat(s.cnt == 17'h0_0000, s.hi_be, s.qout[63:32], engine_data_reg);
		end
	end

	// the beat register only pulls when empty, one idle cycle per dword
	assign pop_if.ready = !s.beat_valid;

	always_comb
	begin
		next_s = s;
		// pixel attributes registered so the outputs leave a flop
		next_s.pmask = plane_mask_reg;
		next_s.rop = raster_op_config_reg;
		// engine sequencing
		case (s.st)
			ST_IDLE:
			begin
				next_s.trig_ready = 1'b1;
				if (trig_valid && s.trig_ready && op_mode == MODE_DMA_WRITE)
				begin
					next_s.st = ST_READ;
					next_s.busy = 1'b1;
					next_s.trig_ready = 1'b0;
					next_s.rd_req = 1'b1;
					next_s.rd_addr = trig_addr;
					next_s.rd_fmt = {src_byte, src_bitmap};
					next_s.total = {1'b0, trig_data[RC_LSB +: 16]} + 17'h0_0001;
					next_s.cnt = {1'b0, trig_data[RC_LSB +: 16]} + 17'h0_0001;
					next_s.lmask = trig_data[ML_LSB +: 8];
					next_s.rmask = trig_data[MR_LSB +: 8];
					next_s.dw_addr = dma_base_addr_reg;
					next_s.need_start = 1'b1;
					next_s.done_seen = 1'b0;
				end
				else if (trig_valid && s.trig_ready && op_mode == MODE_LINE)
				begin
					next_s.st = ST_LINE;
					next_s.busy = 1'b1;
					next_s.trig_ready = 1'b0;
					next_s.packed8 = (dst_bitmap == FMT_PACKED8);
					// low address bits only matter for packed 8-bpp
					next_s.cur = (dst_bitmap == FMT_PACKED8) ? {trig_addr[31:2], trig_data[LB_LSB +: 2]}
						: {trig_addr[31:2], 2'b00};
					next_s.pat = trig_data[PAT_LSB +: 16];
					next_s.err = bresenham_init_len_reg[IERR_LSB +: 16];
					next_s.len = bresenham_init_len_reg[LEN_LSB +: 4];
					next_s.wr_valid = 1'b1;
					next_s.wr_data = trig_data[PAT_LSB] ? foreground_colour_reg : background_colour_reg;
				end
			end
			ST_READ:
			begin
				if (!s.rd_req)
					next_s.rd_req = 1'b1; // reissue one cycle after the priming read
				else if (fb_rd_valid)
				begin
					next_s.rd_req = 1'b0;
					next_s.residue = fb_rd_data;
					next_s.qout = shifted;
					next_s.cnt = s.cnt - 17'h0_0001;
					next_s.rd_addr = s.rd_addr + QWORD_STEP;
					next_s.st = ST_LO;
					if (s.total == 17'h0_0001) // a single read uses no edge mask
					begin
						next_s.lo_en = 1'b1;
						next_s.hi_en = 1'b1;
						next_s.lo_be = BE_ALL;
						next_s.hi_be = BE_ALL;
					end
					else if (s.cnt == s.total) // priming read, shifter output dropped
					begin
						next_s.st = ST_READ;
					end
					else if (s.cnt == s.total - 17'h0_0001) // left edge, also last when only two reads
					begin
						next_s.lo_en = (s.lmask[3:0] != 4'h0);
						next_s.hi_en = 1'b1;
						next_s.lo_be = s.lmask[3:0];
						next_s.hi_be = s.lmask[7:4];
					end
					else if (s.cnt > 17'h0_0001)
					begin
						next_s.lo_en = 1'b1;
						next_s.hi_en = 1'b1;
						next_s.lo_be = BE_ALL;
						next_s.hi_be = BE_ALL;
					end
					else
					begin
						next_s.lo_en = 1'b1;
						next_s.hi_en = (s.rmask[7:4] != 4'h0);
						next_s.lo_be = s.rmask[3:0];
						next_s.hi_be = s.rmask[7:4];
					end
				end
			end
			ST_LO:
				if (!s.lo_en || push_if.ready)
					next_s.st = ST_HI;
			ST_HI:
				if (!s.hi_en || push_if.ready)
				begin
					next_s.st = (s.cnt == 17'h0_0000) ? ST_DRAIN : ST_READ;
					next_s.rd_req = (s.cnt != 17'h0_0000);
				end
			ST_DRAIN:
				// stay busy until the last beat has been acknowledged on the bus
				if (s.done_seen)
				begin
					next_s.st = ST_IDLE;
					next_s.busy = 1'b0;
				end
			ST_LINE:
				if (fb_wr_ready) // step after each accepted pixel
				begin
					if (s.err[15])
					begin
						next_s.cur = s.cur + sext16(bresenham_term_reg_a[AINC_LSB +: 16]);
						next_s.err = s.err + bresenham_term_reg_a[EINC_LSB +: 16];
					end
					else
					begin
						next_s.cur = s.cur + sext16(bresenham_term_reg_b[AINC_LSB +: 16]);
						next_s.err = s.err - bresenham_term_reg_b[EINC_LSB +: 16];
					end
					// non-packed formats keep the lane at zero
					if (!s.packed8)
						next_s.cur[1:0] = 2'b00;
					next_s.len = s.len - 4'h1;
					next_s.pat = {1'b0, s.pat[15:1]};
					next_s.wr_data = s.pat[1] ? foreground_colour_reg : background_colour_reg;
					if (s.len == 4'h1)
					begin
						// zero start length wraps to sixteen pixels
						next_s.st = ST_IDLE;
						next_s.wr_valid = 1'b0;
						next_s.busy = 1'b0;
					end
				end
			default:
				next_s.st = ST_IDLE;
		endcase

		// bus master beat register
		if (s.beat_valid)
		begin
			if (pci_ack)
			begin
				next_s.beat_valid = 1'b0;
				next_s.beat_start = 1'b0;
				next_s.dw_addr = s.dw_addr + DWORD_STEP;
				if (s.beat_last)
				begin
					next_s.done_seen = 1'b1;
					next_s.need_start = 1'b1;
				end
				if (pci_stop)
					next_s.need_start = 1'b1;
			end
			else if (pci_stop)
				next_s.beat_start = 1'b1;
		end
		else if (pop_if.valid)
		begin
			next_s.beat_valid = 1'b1;
			next_s.beat_start = s.need_start;
			next_s.need_start = 1'b0;
			next_s.beat_last = pop_if.data[36];
			next_s.beat_be = pop_if.data[35:32];
			next_s.beat_data = pop_if.data[31:0];
		end
	end

	// all engine state in one register
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			s <= '0;
			s.st <= ST_IDLE;
			s.rd_addr <= ADDR_RESET;
			s.dw_addr <= ADDR_RESET;
			s.need_start <= 1'b1;
		end
		else
			s <= next_s;
	end

	// outputs straight from the state register
	assign trig_ready = s.trig_ready;
	assign busy = s.busy;
	assign fb_rd_req = s.rd_req;
	assign fb_rd_addr = s.rd_addr;
	assign fb_rd_format = s.rd_fmt;
	assign fb_wr_valid = s.wr_valid;
	assign fb_wr_dword = s.cur[31:2];
	assign fb_wr_byte = s.cur[1:0];
	assign fb_wr_data = s.wr_data;
	// plane mask and rop pass with every pixel, never on the dma path
	assign fb_wr_plane_mask = s.pmask;
	assign fb_wr_rop = s.rop;
	assign pci_valid = s.beat_valid;
	assign pci_start = s.beat_start;
	assign pci_addr = s.dw_addr;
	assign pci_data = s.beat_data;
	assign pci_be = s.beat_be;
	assign pci_last = s.beat_last;
endmodule

// >>> dwl_pkg.sv
// shared constants and types for the span copy and line engine
package dwl_pkg;
	// operating mode codes on the mode port
	localparam logic [1:0] MODE_DMA_WRITE = 2'h1;
	localparam logic [1:0] MODE_LINE = 2'h2;
	// destination bitmap code for packed 8-bpp
	localparam logic [1:0] FMT_PACKED8 = 2'h0;
	// trigger data fields, dma write
	localparam int RC_LSB = 16;
	localparam int ML_LSB = 8;
	localparam int MR_LSB = 0;
	// trigger data fields, line
	localparam int LB_LSB = 16;
	localparam int PAT_LSB = 0;
	// bresenham register fields
	localparam int AINC_LSB = 16;
	localparam int EINC_LSB = 0;
	localparam int IERR_LSB = 16;
	localparam int LEN_LSB = 0;
	// stepping and reset values
	localparam logic [31:0] QWORD_STEP = 32'h0000_0008;
	localparam logic [31:0] DWORD_STEP = 32'h0000_0004;
	localparam logic [3:0] BE_ALL = 4'hF;
	localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
	// fifo geometry
	localparam int BEAT_W = 37;
	localparam int FIFO_DEPTH = 8;
	// engine states
	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b000,
		ST_READ = 3'b001,
		ST_LO = 3'b010,
		ST_HI = 3'b011,
		ST_DRAIN = 3'b100,
		ST_LINE = 3'b101
	} dwl_state_t;
endpackage

// >>> dwl_stream_if.sv
// valid/ready carrier between the engine and its beat fifo
`timescale 1ns/1ps
interface dwl_stream_if #(parameter int W = 8);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport source (output valid, output data, input ready);
	modport sink (input valid, input data, output ready);
endinterface

// >>> dwl_fifo.sv
// parameterised beat fifo with honest full and empty
`timescale 1ns/1ps
module dwl_fifo #(parameter int W = 8, parameter int DEPTH = 8)
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// fill and drain sides
	dwl_stream_if.sink wr,
	dwl_stream_if.source rd
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed
	{
		logic [AW:0] wp;
		logic [AW:0] rp;
	} dwl_fifo_state_t;
	dwl_fifo_state_t s, next_s;
	logic [W-1:0] mem [DEPTH];
	logic full;
	logic empty;
	logic do_wr;
	logic do_rd;

	// extra pointer bit tells full from empty
	assign empty = (s.wp == s.rp);
	assign full = (s.wp[AW] != s.rp[AW]) && (s.wp[AW-1:0] == s.rp[AW-1:0]);
	assign wr.ready = !full;
	assign rd.valid = !empty;
	assign rd.data = mem[s.rp[AW-1:0]];
	assign do_wr = wr.valid && !full;
	assign do_rd = rd.ready && !empty;

	// pointer advance
	always_comb
	begin
		next_s = s;
		if (do_wr)
			next_s.wp = s.wp + 1'b1;
		if (do_rd)
			next_s.rp = s.rp + 1'b1;
	end

	// storage has no reset, pointers do
	always_ff @(posedge mclk)
	begin
		if (rst)
			s <= '0;
		else
			s <= next_s;
		if (do_wr)
			mem[s.wp[AW-1:0]] <= wr.data;
	end
endmodule

// >>> dwl_engine_properties.sv
// port relations of the span copy and line engine
`timescale 1ns/1ps
module dwl_engine_properties
	import dwl_pkg::*;
(
	// clock, reset, trigger
	input wire logic mclk,
	input wire logic rst,
	input wire logic trig_valid,
	input wire logic trig_ready,
	input wire logic [1:0] op_mode,
	input wire logic busy,
	// memory side
	input wire logic fb_rd_req,
	input wire logic [31:0] fb_rd_addr,
	input wire logic fb_rd_valid,
	input wire logic fb_wr_valid,
	input wire logic [31:0] fb_wr_data,
	input wire logic fb_wr_ready,
	// bus master side
	input wire logic pci_valid,
	input wire logic pci_start,
	input wire logic [31:0] pci_addr,
	input wire logic [31:0] pci_data,
	input wire logic pci_last,
	input wire logic pci_ack,
	input wire logic pci_stop
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (rst);
	property p_take;
		trig_valid && trig_ready && (op_mode == MODE_DMA_WRITE || op_mode == MODE_LINE) |=> busy && !trig_ready;
	endproperty
	a_take: assert property (p_take) else $error("trigger not taken");
	property p_idle;
		!busy |-> !pci_valid && !fb_rd_req && !fb_wr_valid;
	endproperty
	a_idle: assert property (p_idle) else $error("activity while idle");
	property p_rd_hold;
		fb_rd_req && !fb_rd_valid |=> fb_rd_req && $stable(fb_rd_addr);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read request dropped");
	property p_rd_step;
		fb_rd_req && fb_rd_valid |=> !fb_rd_req && fb_rd_addr == $past(fb_rd_addr) + QWORD_STEP;
	endproperty
	a_rd_step: assert property (p_rd_step) else $error("read address step wrong");
	property p_beat_hold;
		pci_valid && !pci_ack |=> pci_valid && $stable(pci_addr) && $stable(pci_data);
	endproperty
	a_beat_hold: assert property (p_beat_hold) else $error("beat changed before ack");
	property p_beat_step;
		pci_valid && pci_ack |=> !pci_valid && pci_addr == $past(pci_addr) + DWORD_STEP;
	endproperty
	a_beat_step: assert property (p_beat_step) else $error("dword address step wrong");
	property p_restart;
		pci_valid && pci_stop && !pci_ack |=> pci_valid && pci_start;
	endproperty
	a_restart: assert property (p_restart) else $error("burst not restarted");
	property p_last;
		pci_valid && pci_ack && pci_last |-> ##2 !busy;
	endproperty
	a_last: assert property (p_last) else $error("busy after final dword");
	property p_pix_hold;
		fb_wr_valid && !fb_wr_ready |=> fb_wr_valid && $stable(fb_wr_data);
	endproperty
	a_pix_hold: assert property (p_pix_hold) else $error("pixel changed before accept");
endmodule
bind dwl_engine dwl_engine_properties u_props (.mclk, .rst, .trig_valid, .trig_ready, .op_mode, .busy, .fb_rd_req,
	.fb_rd_addr, .fb_rd_valid, .fb_wr_valid, .fb_wr_data, .fb_wr_ready, .pci_valid, .pci_start, .pci_addr, .pci_data,
	.pci_last, .pci_ack, .pci_stop);

// >>> dwl_far_model.sv
// far side model: frame buffer, pixel sink and bus target
`timescale 1ns/1ps
module dwl_far_model
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// frame buffer
	input wire logic fb_rd_req,
	input wire logic [31:0] fb_rd_addr,
	output logic fb_rd_valid,
	output logic [63:0] fb_rd_data,
	input wire logic fb_wr_valid,
	output logic fb_wr_ready,
	// bus target
	input wire logic pci_valid,
	output logic pci_ack,
	output logic pci_stop
);
	logic [7:0] r;
	logic go;
	initial
	begin
		{fb_rd_valid, fb_wr_ready, pci_ack, pci_stop} = 4'h0;
		fb_rd_data = 64'h0;
	end
	// random waits; idle data toggles so a stale word never matches
	always @(posedge mclk)
	begin
		r = $urandom;
		go = fb_rd_req && !fb_rd_valid && r[1:0] != 2'h0;
		fb_rd_valid <= !rst && go;
		fb_rd_data <= go ? {fb_rd_addr + 32'h0000_1111, fb_rd_addr} : ~fb_rd_data;
		fb_wr_ready <= !rst && fb_wr_valid && (r[2] || r[3]);
		pci_ack <= !rst && pci_valid && !pci_ack && !pci_stop && r[5:4] != 2'h0;
		pci_stop <= !rst && pci_valid && !pci_ack && !pci_stop && r[5:4] == 2'h0 && r[6];
	end
endmodule

// >>> dwl_engine_bench.sv
// self-checking bench for the span copy and line engine
`timescale 1ns/1ps
module dwl_engine_bench
	import dwl_pkg::*;
;
	// stimulus
	logic mclk = 0, rst = 1, trig_valid = 0;
	logic [31:0] trig_addr = 0, trig_data = 0, engine_data_reg = 0, dma_base_addr_reg = 0, plane_mask_reg = 0;
	logic [31:0] foreground_colour_reg = 0, background_colour_reg = 0, bresenham_term_reg_a = 0;
	logic [31:0] bresenham_term_reg_b = 0, bresenham_init_len_reg = 0;
	logic [1:0] op_mode = 0, src_byte = 0, dst_bitmap = 0;
	logic [2:0] src_bitmap = 0;
	logic [3:0] pixel_shift_reg = 0, raster_op_config_reg = 0;
	// observed
	logic trig_ready, busy, fb_rd_req, fb_rd_valid, fb_wr_valid, fb_wr_ready, pci_valid, pci_start, pci_last;
	logic pci_ack, pci_stop;
	logic [31:0] fb_rd_addr, fb_wr_data, fb_wr_plane_mask, pci_addr, pci_data, db;
	logic [63:0] fb_rd_data, le;
	logic [4:0] fb_rd_format;
	logic [29:0] fb_wr_dword;
	logic [1:0] fb_wr_byte;
	logic [3:0] fb_wr_rop, pci_be;
	logic [68:0] pq[$], pe;
	logic [63:0] lq[$];
	logic [31:0] ra = 0;
	logic fs = 0;
	int miscompares = 0, num_checks = 0, cyc = 0;
	always #4 mclk = ~mclk;
	dwl_engine u_dut (.mclk, .rst, .trig_valid, .trig_addr, .trig_data, .trig_ready, .op_mode, .src_bitmap, .src_byte,
		.dst_bitmap, .engine_data_reg, .dma_base_addr_reg, .pixel_shift_reg, .raster_op_config_reg, .plane_mask_reg,
		.foreground_colour_reg, .background_colour_reg, .bresenham_term_reg_a, .bresenham_term_reg_b,
		.bresenham_init_len_reg, .busy, .fb_rd_req, .fb_rd_addr, .fb_rd_format, .fb_rd_valid, .fb_rd_data,
		.fb_wr_valid, .fb_wr_dword, .fb_wr_byte, .fb_wr_data, .fb_wr_plane_mask, .fb_wr_rop, .fb_wr_ready,
		.pci_valid, .pci_start, .pci_addr, .pci_data, .pci_be, .pci_last, .pci_ack, .pci_stop);
	dwl_far_model u_far (.mclk, .rst, .fb_rd_req, .fb_rd_addr, .fb_rd_valid, .fb_rd_data, .fb_wr_valid,
		.fb_wr_ready, .pci_valid, .pci_ack, .pci_stop);
	task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic end_sim();
		if (miscompares == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic push(input logic [3:0] be, input logic [31:0] d);
		pq.push_back({1'b0, be, db, d});
		db += DWORD_STEP;
	endtask
	// hold the write until ready is seen, then wait out the operation
	task automatic trig(input logic [1:0] m, input logic [31:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk);
		op_mode <= m;
		trig_addr <= a;
		trig_data <= d;
		trig_valid <= 1'b1;
		n = 0;
		do
			@(negedge mclk);
		while (trig_ready !== 1'b1 && ++n < 100);
		@(posedge mclk);
		trig_valid <= 1'b0;
		n = 0;
		do
			@(negedge mclk);
		while ((busy !== 1'b0 || pq.size() + lq.size() != 0) && ++n < 3000);
		check("done", pq.size() + lq.size(), 0);
	endtask
	// a hung run counts as a mismatch
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			miscompares++;
			end_sim();
		end
	end
	// oldest note is compared whenever a beat or pixel is accepted
	always @(posedge mclk)
	begin
		if (pci_valid === 1'b1 && pci_ack === 1'b1)
		begin
			check("pci_queued", pq.size() != 0, 1'b1);
			pe = (pq.size() != 0) ? pq.pop_front() : 69'h0;
			check("pci_start", pci_start, fs);
			fs = 1'b0;
			check("pci_data", pci_data, pe[31:0]);
			check("pci_addr", pci_addr, pe[63:32]);
			check("pci_be", pci_be, pe[67:64]);
			check("pci_last", pci_last, pe[68]);
		end
		// a cut burst must be started afresh on its next beat
		if (pci_valid === 1'b1 && pci_stop === 1'b1)
			fs = 1'b1;
		if (fb_rd_req === 1'b1 && fb_rd_valid === 1'b1)
		begin
			check("rd_addr", fb_rd_addr, ra);
			check("rd_format", fb_rd_format, {src_byte, src_bitmap});
			ra += QWORD_STEP;
		end
		if (fb_wr_valid === 1'b1 && fb_wr_ready === 1'b1)
		begin
			check("pixel_queued", lq.size() != 0, 1'b1);
			le = (lq.size() != 0) ? lq.pop_front() : 64'h0;
			check("pixel_addr", {fb_wr_dword, fb_wr_byte}, le[63:32]);
			check("pixel_data", fb_wr_data, le[31:0]);
			check("pixel_rop", {fb_wr_rop, fb_wr_plane_mask}, {raster_op_config_reg, plane_mask_reg});
		end
	end
	initial
	begin
		logic [31:0] a, s, m, fg, bg, cur;
		logic [127:0] w;
		logic [63:0] q, rs;
		logic [15:0] i1;
		logic [7:0] lm, rm;
		logic [3:0] sh, lb, hb, ln;
		int n, er;
		void'($urandom(93));
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		// span copies of one to four reads with varied masks and shift
		for (int k = 0; k < 6; k++)
		begin
			@(posedge mclk);
			n = (k == 5) ? 1 : 2 + k % 3; // a one-read span reuses the residue of the copy before
			lm = $urandom;
			rm = $urandom;
			if (k == 0)
				lm[3:0] = 4'h0;
			if (k == 4)
				rm[7:4] = 4'h0;
			sh = $urandom_range(7);
			m = $urandom;
			s = $urandom & 32'hFFFF_FFE0;
			db = $urandom & 32'hFFFF_FFFC;
			src_bitmap <= $urandom;
			src_byte <= $urandom;
			dst_bitmap <= FMT_PACKED8;
			engine_data_reg <= m;
			pixel_shift_reg <= sh;
			dma_base_addr_reg <= db;
			a = s;
			ra = s;
			fs = 1'b1;
			for (int i = 0; i < n; i++)
			begin
				q = {a + 32'h0000_1111, a};
				w = {q, rs} >> (8 * sh);
				rs = q;
				a += QWORD_STEP;
				w[63:0] &= {m, m};
				lb = (n == 1) ? BE_ALL : (i == 1) ? lm[3:0] : (i == n - 1) ? rm[3:0] : BE_ALL;
				hb = (n == 1) ? BE_ALL : (i == 1) ? lm[7:4] : (i == n - 1) ? rm[7:4] : BE_ALL;
				if ((i > 0 || n == 1) && (i != 1 || lb != 4'h0))
					push(lb, w[31:0]);
				if ((i > 0 || n == 1) && (i != n - 1 || i <= 1 || hb != 4'h0))
					push(hb, w[63:32]);
			end
			pq[pq.size() - 1][68] = 1'b1;
			trig(MODE_DMA_WRITE, s, {16'(n - 1), lm, rm});
		end
		// lines: packed 8-bpp with lane bits, then a full segment elsewhere
		for (int j = 0; j < 2; j++)
		begin
			@(posedge mclk);
			a = $urandom;
			s = $urandom;
			fg = $urandom;
			bg = $urandom;
			ln = j ? 4'h0 : 4'($urandom_range(15, 1));
			i1 = j ? 16'h0004 : 16'h0001;
			dst_bitmap <= j ? 2'h1 : FMT_PACKED8;
			foreground_colour_reg <= fg;
			background_colour_reg <= bg;
			raster_op_config_reg <= $urandom;
			plane_mask_reg <= $urandom;
			bresenham_term_reg_a <= {i1, 16'h0002};
			bresenham_term_reg_b <= {16'hFF04, 16'h0003};
			bresenham_init_len_reg <= {16'hFFFD, 12'h000, ln};
			cur = {a[31:2], j ? 2'h0 : s[17:16]};
			er = -3;
			for (int p = 0; p < (ln == 4'h0 ? 16 : ln); p++)
			begin
				lq.push_back({cur, s[p] ? fg : bg});
				cur += er < 0 ? {{16{i1[15]}}, i1} : 32'hFFFF_FF04;
				er = er < 0 ? er + 2 : er - 3;
			end
			trig(MODE_LINE, a, s);
		end
		end_sim();
	end
endmodule
